// ==== common/fault_mon_pkg.sv ====
// package: constants and carrier types of the fault and safe-state monitor
package fault_mon_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ            = 50_000_000;
	localparam int FAULT_REPORT_US   = 5000;
	localparam int FRAME_MAX_US      = 1000;
	localparam int FAULT_REPORT_CYC  = FAULT_REPORT_US * (CLK_HZ / 1_000_000);
	localparam int FRAME_MAX_CYC     = FRAME_MAX_US * (CLK_HZ / 1_000_000);
	// periodic resets may not toggle the line near a valid pwm rate:
	// hold the line released this long after every reset
	localparam int RESET_HOLD_US     = 20_000;
	localparam int RESET_HOLD_CYC    = RESET_HOLD_US * (CLK_HZ / 1_000_000);

	// ----------------------------------------------------------------
	// widths and duty limits (percent)
	// ----------------------------------------------------------------
	localparam int ANGLE_W           = 12;
	localparam logic [6:0] DIAG_LOW_MAX  = 7'h19;
	localparam logic [6:0] DIAG_HIGH_MIN = 7'h4B;
	localparam logic [6:0] DIAG_HIGH_MAX = 7'h64;
	localparam logic [6:0] DIAG_LOW_RST  = 7'h0A;
	localparam logic [6:0] DIAG_HIGH_RST = 7'h5A;

	typedef enum logic [1:0] {REACT_INDICATE, REACT_WRONG, REACT_SILENT} react_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                 fault;
		logic                 builtin_self_test_or_reset;
		logic                 valid;
		logic [ANGLE_W-1:0]   angle;
		logic [6:0]           diag_duty;
		logic                 use_diag;
		logic                 force_bad_crc;
	} frame_stat_t;
endpackage

// ==== hw/pulse_catch.sv ====
// module: sticky event catcher, holds a fault until level gone and reported once
module pulse_catch
	import fault_mon_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic level,
	input  wire logic consume,
	output logic      held
);
	typedef struct packed {
		logic held;
	} pc_state_t;

	pc_state_t s_r;
	pc_state_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		// set wins over the consume in the same cycle
		if (consume)
			s_nxt.held = 1'b0;
		if (level)
			s_nxt.held = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign held = s_r.held;

	a_level_held: assert property (@(posedge clk) disable iff (!rst_b)
		level |=> held) else $error("fault level not held");
endmodule

// ==== hw/fault_mon.sv ====
// module: supervision of supply faults, resets and safe-state output reaction
module fault_mon
	import fault_mon_pkg::*;
#(
	// quiet time after reset; only a bench shortens it
	parameter int HOLD_CYC = RESET_HOLD_CYC
)
(
	input  wire logic               CLOCK,
	input  wire logic               RST_B,
	input  wire logic               UV_CMP,
	input  wire logic               OV_CMP,
	input  wire logic               INT_FAULT,
	input  wire logic               BUILTIN_SELF_TEST_ERR,
	input  wire logic               PWM_MODE,
	input  wire react_t             REACT_SEL,
	input  wire logic [6:0]         DIAG_LOW_CFG,
	input  wire logic [6:0]         DIAG_HIGH_CFG,
	input  wire logic [ANGLE_W-1:0] ANGLE_IN,
	input  wire logic               FRAME_START,
	input  wire logic               FRAME_ABORT,
	input  wire logic               LINK_DRIVE,
	input  wire logic               LINK_LEVEL,
	output logic                    PIN_OUT,
	output logic                    PIN_OE_B,
	output logic                    TX_ENABLE,
	output frame_stat_t             FRAME_STAT
);
	// ----------------------------------------------------------------
	// reset release and input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_b_int;

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_b_int = rst_sync_r[1];

	// comparator levels come from the analog domain
	logic [2:0] uv_sy_r;
	logic [2:0] ov_sy_r;
	logic       uv_f_r;
	logic       ov_f_r;

	always_ff @(posedge CLOCK or negedge rst_b_int)
	begin
		if (!rst_b_int)
		begin
			uv_sy_r <= 3'h0;
			ov_sy_r <= 3'h0;
			uv_f_r  <= 1'b0;
			ov_f_r  <= 1'b0;
		end
		else
		begin
			uv_sy_r <= {uv_sy_r[1:0], UV_CMP};
			ov_sy_r <= {ov_sy_r[1:0], OV_CMP};
			if (uv_sy_r[1] == uv_sy_r[2])
				uv_f_r <= uv_sy_r[2];
			if (ov_sy_r[1] == ov_sy_r[2])
				ov_f_r <= ov_sy_r[2];
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum {ST_HOLD, ST_RUN, ST_OVER} mode_t;

	function automatic logic [6:0] clip_duty(input logic [6:0] v, input logic [6:0] lo,
		input logic [6:0] hi);
		clip_duty = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	typedef struct packed {
		mode_t               mode;
		logic [31:0]         hold_cnt;
		logic                rst_seen;
		logic [31:0]         frame_cnt;
		logic                in_frame;
		frame_stat_t         stat;
	} fm_state_t;

	fm_state_t s_r;
	fm_state_t s_nxt;
	logic      fault_held;
	logic      builtin_self_test_held;
	logic      frame_edge;

	// internal reset: filtered undervoltage only; the pin reset acts through rst_b_int
	logic       int_rst;
	logic [1:0] catch_lvl;
	logic [1:0] catch_held;
	assign int_rst    = uv_f_r;
	// a start that meets an internal reset is dropped, not half taken
	assign frame_edge = FRAME_START && s_r.mode == ST_RUN && !s_r.in_frame && !int_rst;
	// self test errors are caught apart so they keep the high duty band
	assign catch_lvl  = {BUILTIN_SELF_TEST_ERR, INT_FAULT | ov_f_r};
	assign fault_held = catch_held[0];
	assign builtin_self_test_held  = catch_held[1];

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_catch
			pulse_catch u_catch (
				.clk     (CLOCK),
				.rst_b   (rst_b_int),
				.level   (catch_lvl[g]),
				.consume (frame_edge),
				.held    (catch_held[g])
			);
		end
	endgenerate

	always_comb
	begin
		s_nxt = s_r;
		unique case (s_r.mode)
			ST_HOLD:
			begin
				// long quiet time after any reset kills pwm-like toggling
				if (s_r.hold_cnt >= 32'(HOLD_CYC - 1))
					s_nxt.mode = ST_RUN;
				else
					s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
			end
			ST_RUN:
			begin
				if (ov_f_r)
					s_nxt.mode = ST_OVER;
			end
			ST_OVER:
			begin
				if (!ov_f_r)
					s_nxt.mode = ST_RUN;
			end
		endcase
		if (s_r.in_frame)
		begin
			s_nxt.frame_cnt = s_r.frame_cnt + 32'h1;
			// an interrupted or overlong exchange is dropped
			if (FRAME_ABORT || ov_f_r
				|| s_r.frame_cnt >= 32'(FRAME_MAX_CYC - 1))
				s_nxt.in_frame = 1'b0;
			else if (FRAME_START && s_r.frame_cnt != 32'h0)
				s_nxt.in_frame = 1'b0;
		end
		if (frame_edge)
		begin
			s_nxt.in_frame       = 1'b1;
			s_nxt.frame_cnt      = 32'h0;
			// snapshot once per frame so a frame stays self-consistent
			s_nxt.stat.fault     = fault_held;
			s_nxt.stat.builtin_self_test_or_reset = s_r.rst_seen | builtin_self_test_held;
			s_nxt.rst_seen       = 1'b0;
			s_nxt.stat.valid     = !fault_held && !builtin_self_test_held && !ov_f_r && !uv_f_r;
			s_nxt.stat.angle     = ANGLE_IN;
			s_nxt.stat.use_diag  = PWM_MODE && (fault_held || s_r.rst_seen || builtin_self_test_held);
			s_nxt.stat.force_bad_crc = fault_held && REACT_SEL == REACT_WRONG;
			if (fault_held)
				s_nxt.stat.diag_duty = clip_duty(DIAG_LOW_CFG, 7'h0, DIAG_LOW_MAX);
			else
				s_nxt.stat.diag_duty = clip_duty(DIAG_HIGH_CFG, DIAG_HIGH_MIN,
					DIAG_HIGH_MAX);
		end
	end

	always_ff @(posedge CLOCK or negedge rst_b_int)
	begin
		if (!rst_b_int)
		begin
			s_r          <= '0;
			s_r.mode     <= ST_HOLD;
			s_r.rst_seen <= 1'b1;
		end
		else if (int_rst)
		begin
			s_r          <= '0;
			s_r.mode     <= ST_HOLD;
			s_r.rst_seen <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic silent;
	assign silent = s_r.stat.fault && REACT_SEL == REACT_SILENT;

	// pin released in reset, hold, overvoltage or silent reaction
	assign TX_ENABLE  = s_r.mode == ST_RUN && !int_rst && !silent;
	assign PIN_OE_B   = !(TX_ENABLE && LINK_DRIVE && rst_b_int);
	assign PIN_OUT    = LINK_LEVEL;
	assign FRAME_STAT = s_r.stat;

	// report delay stays under one frame plus the wait for the next start
	a_tristate_rst: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		int_rst |-> PIN_OE_B) else $error("pin driven during reset");
	a_over_quiet: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		s_r.mode == ST_OVER |-> !TX_ENABLE) else $error("sending in overvoltage");
	a_frame_bound: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		s_r.in_frame |-> s_r.frame_cnt < 32'(FRAME_MAX_CYC)) else $error("frame overlong");
	a_diag_low: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		s_r.stat.fault |-> s_r.stat.diag_duty <= DIAG_LOW_MAX) else $error("low duty");
	a_valid_ok: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		frame_edge && (fault_held || builtin_self_test_held || ov_f_r) |=> !s_r.stat.valid)
		else $error("valid in fault");
	a_fault_rep: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		frame_edge && fault_held |=> s_r.stat.fault) else $error("fault not sent");
	a_reset_rep: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		frame_edge && s_r.rst_seen |=> s_r.stat.builtin_self_test_or_reset) else $error("reset lost");
	a_clear_ok: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		frame_edge && !fault_held |=> !s_r.stat.fault) else $error("stale fault");
	a_abort_ok: assert property (@(posedge CLOCK) disable iff (!rst_b_int)
		s_r.in_frame && FRAME_ABORT |=> !s_r.in_frame) else $error("abort hung");
endmodule

// ==== dv/ecu_model.sv ====
// partner model: control unit listening on the shared sensor output line
module ecu_model
(
	input  wire logic clk,
	input  wire logic pin_out,
	input  wire logic pin_oe_b,
	output logic      line,
	output int        edges
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev_r = 1'b1;
	int   cnt_r  = 0;
	// released line floats to the pull-up level
	assign line  = pin_oe_b ? 1'b1 : pin_out;
	assign edges = cnt_r;
	// the model only listens and never drives the pin
	// count changes so reset cycling shows up as toggling
	always @(posedge clk)
	begin
		if (line !== prev_r)
			cnt_r <= cnt_r + 1;
		prev_r <= line;
	end
endmodule

// ==== dv/sensor_fault_safe_state_monitor_tb.sv ====
// testbench: fault supervision and safe-state reaction of the monitor
module sensor_fault_safe_state_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fault_mon_pkg::*;
	// shortened quiet time keeps the run short; the contract is unchanged
	localparam int HOLD = 2000;
	localparam int CAP  = 20000;
	// ----------------------------------------------------------------
	// stimulus rows: e = fault, self test or reset seen, valid, use_diag, bad crc, oe_b
	// ----------------------------------------------------------------
	typedef struct {
		logic        f;
		logic        b;
		logic        pwm;
		react_t      rs;
		logic [6:0]  lo;
		logic [11:0] ang;
		logic [5:0]  e;
		logic [6:0]  duty;
	} row_t;
	logic clk = 1'b0, rst_b = 1'b0, uv = 1'b0, ov = 1'b0, flt = 1'b0, builtin_self_test = 1'b0;
	logic pwm = 1'b0, start = 1'b0, abort = 1'b0, drv = 1'b1, lvl = 1'b0;
	react_t      rs  = REACT_INDICATE;
	logic [6:0]  lo  = 7'h00;
	logic [6:0]  hi  = 7'h70;
	logic [11:0] ang = 12'h000;
	logic        pin_out, oe_b, tx_en, line;
	frame_stat_t st;
	int          edges, bad_count = 0, comparisons = 0, cyc = 0, n = 0;
	row_t        rows[6];
	always #10 clk = ~clk;
	fault_mon #(.HOLD_CYC(HOLD)) uut (.CLOCK(clk), .RST_B(rst_b), .UV_CMP(uv), .OV_CMP(ov),
		.INT_FAULT(flt), .BUILTIN_SELF_TEST_ERR(builtin_self_test), .PWM_MODE(pwm), .REACT_SEL(rs), .DIAG_LOW_CFG(lo),
		.DIAG_HIGH_CFG(hi), .ANGLE_IN(ang), .FRAME_START(start), .FRAME_ABORT(abort),
		.LINK_DRIVE(drv), .LINK_LEVEL(lvl), .PIN_OUT(pin_out), .PIN_OE_B(oe_b),
		.TX_ENABLE(tx_en), .FRAME_STAT(st));
	ecu_model ecu (.clk(clk), .pin_out(pin_out), .pin_oe_b(oe_b), .line(line), .edges(edges));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(logic [11:0] seen, logic [11:0] want, string msg);
		comparisons++;
		if (seen !== want)
		begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic end_sim();
		$display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic pulse_start();
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic pulse_abort();
		@(posedge clk);
		abort <= 1'b1;
		@(posedge clk);
		abort <= 1'b0;
	endtask
	// two shortened holds and nine frames fit well inside the cap
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == CAP)
		begin
			bad_count++;
			end_sim();
		end
	end
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		rows[0] = '{0, 0, 0, REACT_INDICATE, 7'h00, 12'h123, 6'b011000, 7'h00};
		rows[1] = '{1, 0, 1, REACT_WRONG, 7'h30, 12'h456, 6'b100110, 7'h19};
		rows[2] = '{0, 0, 1, REACT_WRONG, 7'h30, 12'h789, 6'b001000, 7'h00};
		rows[3] = '{0, 1, 1, REACT_SILENT, 7'h05, 12'hABC, 6'b010100, 7'h64};
		rows[4] = '{1, 0, 0, REACT_SILENT, 7'h05, 12'h800, 6'b100001, 7'h00};
		rows[5] = '{0, 0, 0, REACT_INDICATE, 7'h05, 12'hFFF, 6'b001000, 7'h00};
		@(negedge clk);
		check({st !== '0, oe_b, tx_en}, 3'b010, "outputs during reset");
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		for (n = 0; n < 5 * HOLD && tx_en !== 1'b1; n++)
			@(negedge clk);
		check(edges, 0, "line toggled during hold");
		// two edges of reset release, then the full quiet time
		check(12'(n), 12'(HOLD + 3), "hold length after reset");
		$display("test hold done");
		foreach (rows[i])
		begin
			@(posedge clk);
			flt  <= rows[i].f;
			builtin_self_test <= rows[i].b;
			pwm  <= rows[i].pwm;
			rs   <= rows[i].rs;
			lo   <= rows[i].lo;
			ang  <= rows[i].ang;
			@(posedge clk);
			{flt, builtin_self_test} <= 2'b00;
			pulse_start();
			check({st.fault, st.builtin_self_test_or_reset, st.valid, st.use_diag, st.force_bad_crc,
				oe_b}, rows[i].e, "frame flags");
			if (rows[i].e[3])
				check(st.angle, rows[i].ang, "angle word");
			if (rows[i].e[2])
				check(st.diag_duty, rows[i].duty, "diagnostic duty");
			pulse_abort();
			$display("test row %0d done", i);
		end
		@(posedge clk);
		ov <= 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		check({oe_b, tx_en}, 2'b10, "overvoltage must release");
		@(posedge clk);
		ov <= 1'b0;
		repeat (8) @(posedge clk);
		pulse_start();
		check({st.fault, st.valid}, 2'b10, "overvoltage report");
		pulse_abort();
		pulse_start();
		check({st.fault, st.valid}, 2'b01, "recovery after abort");
		$display("test overvoltage done");
		@(posedge clk);
		uv <= 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		check({st !== '0, oe_b, tx_en}, 3'b010, "undervoltage reset");
		@(posedge clk);
		uv <= 1'b0;
		for (n = 0; n < 5 * HOLD && tx_en !== 1'b1; n++)
			@(negedge clk);
		// four edges of filtering, then the quiet time starts again
		check(12'(n), 12'(HOLD + 5), "hold length after undervoltage");
		pulse_start();
		check({st.builtin_self_test_or_reset, st.fault, st.valid}, 3'b101, "reset reported");
		@(posedge clk);
		lvl <= 1'b1;
		drv <= 1'b0;
		@(negedge clk);
		check({oe_b, line, pin_out}, 3'b111, "line released when idle");
		@(posedge clk);
		drv <= 1'b1;
		lvl <= 1'b0;
		@(negedge clk);
		check({oe_b, line, pin_out}, 3'b000, "level driven on line");
		$display("test undervoltage done");
		end_sim();
	end
endmodule
